/* File: etm_far_end.sv */
`timescale 1ns/1ps
module etm_far_end (
    // clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst,
    // bit to send; i_viol repeats the last mark polarity
    input  wire logic          i_bit,
    input  wire logic          i_viol,
    // line side
    output logic               o_bit_en = 1'b0,
    output etm_pkg::etm_rail_s o_rail = '0
);
    import etm_pkg::*;
    logic [1:0] cnt_ff;
    logic       pol_ff;
    always @(negedge i_clk_sys)
    begin
        if (i_rst)
        begin
            cnt_ff <= 2'h0;
            pol_ff <= 1'b0;
            o_bit_en <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 2'h1;
            o_bit_en <= (cnt_ff == 2'h3);
            if (cnt_ff == 2'h3)
            begin
                pol_ff <= pol_ff ^ (i_bit & ~i_viol);
                o_rail <= i_bit ? {pol_ff ^ ~i_viol, pol_ff ^ i_viol} : 2'h0;
            end
        end
    end
endmodule

/* File: etm_fifo.sv */
`timescale 1ns/1ps
module etm_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;
    assign o_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign o_valid = (cnt_ff != '0);
    assign o_data  = mem[rd_ff];
    always_ff @(posedge i_clk_sys)
    begin
        if (push)
            mem[wr_ff] <= i_data;
        if (i_rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: etm_line_path.sv */
`timescale 1ns/1ps
`include "etm_map.svh"
// Contract
// - with all option switches off both directions pass unchanged; receive adds one bit of delay, transmit adds two.
// - pattern 1000 inverts every bit of timeslots 1-31 and leaves timeslot 0 alone.
// - pattern 1001 inverts only bits 1, 2, 5 and 6 of each octet in timeslots 1-31.
// - crc overwrite puts the crc4 multiframe bits into timeslot 0 bit 1, else slot 0 is transparent.
// - signalling pass with modify enable leaves timeslot 16 untouched, inverting 1-15 and 17-31.
// - signalling pass and bit mask select are ignored while modify enable is off.
// - modification applies only to E1; the T1 path never alters payload.
// - T1 receive line code is selectable between plain AMI and B8ZS; transmit always sends AMI.
// - E1 receive line code is selectable between plain AMI and HDB3; transmit always sends AMI.
// - in B8ZS or HDB3 each received code violation pulses marginal data; never in AMI.
module etm_line_path (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // configuration
    input  wire logic              i_is_e1,
    input  wire logic              i_coded,
    input  wire etm_pkg::etm_opt_s i_opt,
    input  wire logic              i_crc_bit,
    // line receive (rails, one bit per enable)
    input  wire logic              i_line_bit_en,
    input  wire etm_pkg::etm_rail_s i_line_rx,
    // modem side transmit towards line
    input  wire logic              i_modem_tx_bit,
    // modem side receive, buffered
    output logic                   o_modem_rx_valid,
    input  wire logic              i_modem_rx_ready,
    output logic                   o_modem_rx_bit,
    // line transmit
    output etm_pkg::etm_rail_s     o_line_tx,
    // status
    output logic                   o_marginal_data,
    output logic                   o_rx_aligned,
    output logic                   o_tx_aligned,
    output logic                   o_rx_overrun
);
    import etm_pkg::*;

    etm_code_e code;
    assign code = !i_coded ? ETM_AMI : (i_is_e1 ? ETM_HDB3 : ETM_B8ZS);

    // receive decode: zeros-run counter tracks substitution windows
    logic       last_pol_ff;
    logic [3:0] zrun_ff;
    wire        rx_mark  = i_line_rx.pos | i_line_rx.neg;
    wire        rx_pol   = i_line_rx.pos;
    wire        bipolar  = rx_mark && (rx_pol == last_pol_ff);
    wire        hdb3_v   = bipolar && (zrun_ff == 4'h3 || zrun_ff == 4'h2);
    wire        b8zs_v   = bipolar && (zrun_ff == 4'h3 || zrun_ff == 4'h6);
    wire        sub_ok   = (code == ETM_HDB3) ? hdb3_v : (code == ETM_B8ZS) ? b8zs_v : 1'b0;
    wire        lcv      = bipolar && !sub_ok && (code != ETM_AMI);
    // substituted marks decode as zero; run count only protects the window
    wire        rx_bit   = rx_mark && !sub_ok && !(code != ETM_AMI && bipolar);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            last_pol_ff     <= 1'b0;
            zrun_ff         <= '0;
            o_marginal_data <= 1'b0;
        end
        else
        begin
            o_marginal_data <= i_line_bit_en && lcv;
            if (i_line_bit_en)
            begin
                if (rx_mark)
                    last_pol_ff <= rx_pol;
                zrun_ff <= rx_bit ? '0 : (zrun_ff == `ETM_SUBST_LEN) ? zrun_ff : zrun_ff + 4'h1;
            end
        end
    end

    // frame tracker and modifier shared form, one per direction
    logic [7:0] rx_pos_ff, tx_pos_ff;
    logic [6:0] rx_sh_ff, tx_sh_ff;
    logic       rx_al_ff, tx_al_ff;
    logic       rx_out_ff, tx_out_ff;

    function automatic logic modify(input logic b, input logic [7:0] pos, input logic al);
        logic [4:0] slot;
        logic [2:0] bitn;
        logic       inv_slot;
        logic [7:0] mask;
        slot = pos[7:3];
        bitn = pos[2:0];
        mask = i_opt.bit_mask_select ? `ETM_MASK_BITS_1256 : `ETM_MASK_ALL;
        // signalling pass and mask only matter under modify enable
        inv_slot = i_opt.payload_modify_enable && slot != `ETM_SLOT_ALIGN
                   && !(i_opt.signalling_slot_pass && slot == `ETM_SLOT_SIGNAL);
        modify = b;
        if (!i_is_e1 || !al)
            modify = b;
        else if (slot == `ETM_SLOT_ALIGN && bitn == `ETM_CRC_BIT_POS
                 && i_opt.crc_overwrite_enable)
            modify = i_crc_bit;
        else if (inv_slot)
            modify = b ^ mask[3'h7 - bitn];
    endfunction

    // alignment: seek the fas word, then trust the bit counter; limitation, no loss check
    wire rx_fas = ({rx_sh_ff, rx_bit} == {1'b0, 7'(`ETM_FAS_WORD)});
    wire tx_fas = ({tx_sh_ff, i_modem_tx_bit} == {1'b0, 7'(`ETM_FAS_WORD)});

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rx_pos_ff <= '0;
            tx_pos_ff <= '0;
            rx_sh_ff  <= '0;
            tx_sh_ff  <= '0;
            rx_al_ff  <= 1'b0;
            tx_al_ff  <= 1'b0;
            rx_out_ff <= 1'b0;
            tx_out_ff <= 1'b0;
        end
        else if (i_line_bit_en)
        begin
            rx_sh_ff  <= {rx_sh_ff[5:0], rx_bit};
            tx_sh_ff  <= {tx_sh_ff[5:0], i_modem_tx_bit};
            rx_pos_ff <= (!rx_al_ff && rx_fas) ? 8'h08 : rx_pos_ff + 8'h01;
            tx_pos_ff <= (!tx_al_ff && tx_fas) ? 8'h08 : tx_pos_ff + 8'h01;
            rx_al_ff  <= rx_al_ff | (i_is_e1 && rx_fas);
            tx_al_ff  <= tx_al_ff | (i_is_e1 && tx_fas);
            rx_out_ff <= modify(rx_bit, rx_pos_ff, rx_al_ff);
            tx_out_ff <= modify(i_modem_tx_bit, tx_pos_ff, tx_al_ff);
        end
    end

    assign o_rx_aligned = rx_al_ff;
    assign o_tx_aligned = tx_al_ff;

    // transmit encode: alternate polarity, AMI only; substitution left to line unit
    logic tx_pol_ff;
    etm_rail_s tx_rail_ff;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            tx_pol_ff  <= 1'b0;
            tx_rail_ff <= '0;
        end
        else if (i_line_bit_en)
        begin
            tx_rail_ff <= '{pos: tx_out_ff && !tx_pol_ff, neg: tx_out_ff && tx_pol_ff};
            if (tx_out_ff)
                tx_pol_ff <= !tx_pol_ff;
        end
    end
    assign o_line_tx = tx_rail_ff;

    // receive bits into fifo; a stalled modem side loses bits and flags it
    logic fifo_ready;
    logic push_ff;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            push_ff      <= 1'b0;
            o_rx_overrun <= 1'b0;
        end
        else
        begin
            push_ff      <= i_line_bit_en;
            o_rx_overrun <= o_rx_overrun | (push_ff && !fifo_ready);
        end
    end

    etm_fifo #(
        .WIDTH (1),
        .DEPTH (`ETM_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_valid   (push_ff),
        .o_ready   (fifo_ready),
        .i_data    (rx_out_ff),
        .o_valid   (o_modem_rx_valid),
        .i_ready   (i_modem_rx_ready),
        .o_data    (o_modem_rx_bit)
    );
endmodule

/* File: etm_line_path_assertions.sv */
`timescale 1ns/1ps
module etm_line_path_assertions (
    // clock and reset
    input wire logic               i_clk_sys,
    input wire logic               i_rst,
    // watched ports
    input wire logic               i_coded,
    input wire logic               i_is_e1,
    input wire logic               i_line_bit_en,
    input wire logic               i_modem_rx_ready,
    input wire logic               o_modem_rx_valid,
    input wire etm_pkg::etm_rail_s o_line_tx,
    input wire logic               o_marginal_data,
    input wire logic               o_rx_aligned
);
    import etm_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_ami; !i_coded && !$past(i_coded) |-> !o_marginal_data; endproperty
    a_ami: assert property (p_ami) else $error("marginal in ami");
    property p_pulse; o_marginal_data |=> !o_marginal_data; endproperty
    a_pulse: assert property (p_pulse) else $error("marginal too long");
    property p_cause; o_marginal_data |-> $past(i_line_bit_en) && $past(i_coded); endproperty
    a_cause: assert property (p_cause) else $error("marginal without bit");
    property p_rail; !(o_line_tx.pos && o_line_tx.neg); endproperty
    a_rail: assert property (p_rail) else $error("both rails high");
    property p_txen; $changed(o_line_tx) |-> $past(i_line_bit_en); endproperty
    a_txen: assert property (p_txen) else $error("tx moved off bit");
    property p_keep; o_rx_aligned |=> o_rx_aligned; endproperty
    a_keep: assert property (p_keep) else $error("alignment lost");
    property p_e1; $rose(o_rx_aligned) |-> $past(i_is_e1); endproperty
    a_e1: assert property (p_e1) else $error("aligned on t1");
    property p_hold; o_modem_rx_valid && !i_modem_rx_ready |=> o_modem_rx_valid; endproperty
    a_hold: assert property (p_hold) else $error("rx bit lost");
endmodule
bind etm_line_path etm_line_path_assertions u_chk (.i_clk_sys, .i_rst, .i_coded, .i_is_e1,
    .i_line_bit_en, .i_modem_rx_ready, .o_modem_rx_valid, .o_line_tx, .o_marginal_data,
    .o_rx_aligned);

/* File: etm_map.svh */
`ifndef ETM_MAP_SVH
`define ETM_MAP_SVH
`define ETM_FAS_WORD        8'h1B
`define ETM_FAS_BITS        7
`define ETM_FRAME_BITS      256
`define ETM_SLOT_SIGNAL     5'h10
`define ETM_SLOT_ALIGN      5'h00
`define ETM_MASK_ALL        8'hFF
`define ETM_MASK_BITS_1256  8'hCC
`define ETM_CRC_BIT_POS     3'h0
`define ETM_FIFO_DEPTH      4
`define ETM_SUBST_LEN       4'h8
`endif

/* File: etm_pkg.sv */
package etm_pkg;
    typedef enum logic [1:0] {ETM_AMI, ETM_B8ZS, ETM_HDB3} etm_code_e;
    typedef struct packed {
        logic payload_modify_enable;
        logic crc_overwrite_enable;
        logic signalling_slot_pass;
        logic bit_mask_select;
    } etm_opt_s;
    typedef struct packed {
        logic pos;
        logic neg;
    } etm_rail_s;
endpackage

/* File: test_e1_timeslot_modifier_line_code.sv */
`timescale 1ns/1ps
module test_e1_timeslot_modifier_line_code;
    import etm_pkg::*;
    localparam logic [15:0] FRM = 16'h1BA5;
    logic        clk = 1'b0, rst = 1'b1, e1 = 1'b1, coded = 1'b0;
    logic        rdy = 1'b1, fbit = 1'b0, viol = 1'b0;
    etm_opt_s    opt = '0;
    logic        en, vld, rbit, marg, ral, tal, ovr;
    etm_rail_s   rail, tx;
    logic        q[$];
    logic        tq[$];
    logic        crc = 1'b1;
    logic [15:0] got;
    int          error_cnt = 0, compares = 0, mcnt = 0;
    logic [3:0]  opts[6] = '{4'h0, 4'h8, 4'h9, 4'h3, 4'hA, 4'h8};
    logic [7:0]  exps[6] = '{8'hA5, 8'h5A, 8'h69, 8'hA5, 8'h5A, 8'hA5};
    initial forever #12.5 clk = ~clk;
    etm_far_end far (.i_clk_sys(clk), .i_rst(rst), .i_bit(fbit), .i_viol(viol),
        .o_bit_en(en), .o_rail(rail));
    etm_line_path dut (.i_clk_sys(clk), .i_rst(rst), .i_is_e1(e1), .i_coded(coded),
        .i_opt(opt), .i_crc_bit(crc), .i_line_bit_en(en), .i_line_rx(rail),
        .i_modem_tx_bit(fbit), .o_modem_rx_valid(vld), .i_modem_rx_ready(rdy),
        .o_modem_rx_bit(rbit), .o_line_tx(tx), .o_marginal_data(marg),
        .o_rx_aligned(ral), .o_tx_aligned(tal), .o_rx_overrun(ovr));
    always @(posedge clk)
    begin
        if (vld === 1'b1 && rdy)
            q.push_back(rbit);
        if (marg === 1'b1)
            mcnt++;
        // rails seen at a bit enable carry the bit taken two enables earlier
        if (en === 1'b1)
            tq.push_back(tx.pos | tx.neg);
    end
    task check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    begin
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task send(input logic b, input logic v);
    begin
        fbit = b;
        viol = v;
        @(posedge en);
        @(negedge clk);
    end
    endtask
    // stray bits ahead of the frame fall out of the 16-bit window;
    // returning two cycles after the enable keeps clear of the next bit's sampling
    task restart(input logic e, input logic c, input logic [3:0] o);
    begin
        rst = 1'b1;
        e1 = e;
        coded = c;
        opt = o;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(posedge en);
        repeat (2) @(negedge clk);
        q.delete();
        tq.delete();
        got = 'x;
    end
    endtask
    task conclude;
    begin
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        check("reset out", 16'h0, {9'h0, tx, marg, ral, tal, ovr, vld});
        for (int k = 0; k < 6; k++)
        begin
            restart(k < 5, 1'b0, opts[k]);
            for (int i = 15; i >= 0; i--)
                send(FRM[i], 1'b0);
            repeat (5) @(negedge clk);
            foreach (q[j])
                got = {got[14:0], q[j]};
            check("rx octets", {8'h1B, exps[k]}, got);
            check("aligned", {15'h0, k < 5}, {15'h0, ral});
            repeat (4) @(negedge clk);
            got = 'x;
            foreach (tq[j])
                got = {got[14:0], tq[j]};
            check("tx octets", {8'h1B, exps[k]}, got);
            check("tx aligned", {15'h0, k < 5}, {15'h0, tal});
        end
        restart(1'b1, 1'b0, 4'h4);
        for (int i = 15; i >= 0; i--)
            send(FRM[i], 1'b0);
        repeat (241) send(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        check("rx crc bit", {15'h0, crc}, {15'h0, q[$]});
        repeat (4) @(negedge clk);
        check("tx crc bit", {15'h0, crc}, {15'h0, tq[$]});
        for (int k = 0; k < 4; k++)
        begin
            restart(k[0], k[1], 4'h0);
            send(1'b1, 1'b0);
            send(1'b1, 1'b0);
            mcnt = 0;
            send(1'b1, 1'b1);
            send(1'b0, 1'b0);
            check("marginal", {15'h0, k[1]}, 16'(mcnt));
        end
        rdy = 1'b0;
        repeat (6) send(1'b0, 1'b0);
        check("overrun", 16'h1, {15'h0, ovr});
        conclude();
    end
    initial
    begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule
